/* File: dv/sac_cmp_model.sv */
// Comparator model standing in for the analog front end.
// Assumes the bench holds level steady through each conversion.
`timescale 1ns/1ps
module sac_cmp_model
  import sac_pkg::*;
(
  // Analog level and trial code
  input wire sac_code_t level,
  input wire sac_code_t dac_trial,
  // Decision
  output logic cmp_above
);
  // High when the level is at or above the trial
  assign cmp_above = (level >= dac_trial);
endmodule

/* File: dv/sar_adc_read_convert_port_tb_top.sv */
// Bench for the converter control port, host side driven by hand.
// Assumes the comparator model in dv/ and the package in rtl/.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("mismatch %0t %h %h", $time, a, b); end end
module sar_adc_read_convert_port_tb_top
  import sac_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n = 1'b1;
  logic rd_conv = 1'b1;
  logic busy_n, result_oe, cmp_above;
  sac_code_t result_bits, dac_trial;
  sac_code_t level = 12'h000;
  int error_cnt = 0;
  int checks = 0;
  int cur_low = 0;
  int last_low = 0;

  sac_port dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .rd_conv(rd_conv), .busy_n(busy_n),
    .result_bits(result_bits), .result_oe(result_oe), .dac_trial(dac_trial), .cmp_above(cmp_above));
  sac_cmp_model cmp (.level(level), .dac_trial(dac_trial), .cmp_above(cmp_above));

  // Clock, 40 ns period
  always #20 clk = ~clk;

  // Length of the last busy pulse, in cycles; settled before busy rises
  always @(negedge clk) begin
    if (busy_n === 1'b0) begin
      cur_low++;
      last_low = cur_low;
    end else begin
      cur_low = 0;
    end
  end

  // Expected code: offset binary with the sign bit flipped
  function automatic sac_code_t exp_code(input sac_code_t v);
    exp_code = {~v[11], v[10:0]};
  endfunction

  task automatic drive(input logic c, input logic r);
    @(posedge clk);
    cs_n <= c;
    rd_conv <= r;
  endtask

  // Waits out a conversion; bus must stay off meanwhile
  task automatic wait_done();
    int k;
    k = 0;
    repeat (3) @(negedge clk);
    while (busy_n === 1'b0 && k < 40) begin
      `CHK(result_oe, 1'b0)
      @(negedge clk);
      k++;
    end
    `CHK(busy_n, 1'b1)
  endtask

  // Read/convert falling with select low, then rising to read
  task automatic sc_rc_start();
    level = 12'h5a3;
    drive(1'b0, 1'b1);
    drive(1'b0, 1'b0);
    wait_done();
    `CHK(last_low, 24)
    `CHK(dac_trial, level)
    `CHK(result_oe, 1'b0)
    drive(1'b0, 1'b1);
    @(negedge clk);
    `CHK(result_oe, 1'b1)
    `CHK(result_bits, exp_code(level))
    `CHK(result_bits[11], 1'b1)
    `CHK(result_bits[0], 1'b1)
  endtask

  // Select falling starts; a second request mid-run is ignored
  task automatic sc_cs_start();
    level = 12'h2c0;
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
    repeat (5) @(negedge clk);
    `CHK(busy_n, 1'b0)
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
    wait_done();
    `CHK(last_low, 24)
    repeat (3) @(negedge clk);
    `CHK(busy_n, 1'b1)
    drive(1'b1, 1'b1);
    drive(1'b0, 1'b1);
    @(negedge clk);
    `CHK(result_oe, 1'b1)
    `CHK(result_bits, exp_code(level))
  endtask

  // Read level held through a conversion: data valid as busy rises
  task automatic sc_busy_read();
    level = 12'h000;
    drive(1'b0, 1'b0);
    drive(1'b0, 1'b1);
    wait_done();
    // capture the whole word at the busy rise
    `CHK(busy_n, 1'b1)
    `CHK(result_oe, 1'b1)
    `CHK(result_bits, exp_code(level))
    drive(1'b1, 1'b1);
    @(negedge clk);
    `CHK(result_oe, 1'b0)
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    drive(1'b0, 1'b1);
    @(negedge clk);
    `CHK(busy_n, 1'b1)
    `CHK(result_bits, 12'h000)
    `CHK(result_oe, 1'b1)
    `CHK(dac_trial, TRIAL_START)
    sc_rc_start();
    sc_cs_start();
    sc_busy_read();
    complete_run();
  end

  // Watchdog
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule

/* File: rtl/sac_conv_if.sv */
// Carrier between the port controller and the approximation core.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface sac_conv_if;
  import sac_pkg::*;
  logic start;
  sac_code_t code;
  logic done;
  modport ctrl (output start, input code, input done);
  modport core (input start, output code, output done);
endinterface

/* File: rtl/sac_pkg.sv */
// Shared constants and types for the converter control port.
// Assumes one 25 MHz clock for every block that imports it.
package sac_pkg;

  // Result width and bit positions
  localparam int RES_W = 12;
  localparam int MSB_POS = 11;
  localparam int LSB_POS = 0;
  typedef logic [RES_W-1:0] sac_code_t;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS = 940;
  // Longest time, so rounded down to whole cycles
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int START_MIN_NS = 40;
  // Least time, rounded up, never below one cycle
  localparam int START_MIN_CYCLES_RAW = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_MIN_CYCLES = (START_MIN_CYCLES_RAW < 1) ? 1 : START_MIN_CYCLES_RAW;

  // Counter layout
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_BITS = CNT_W'(RES_W);

  // Reset and start values
  localparam sac_code_t RESULT_RST = 12'h000;
  localparam sac_code_t TRIAL_START = 12'h800;

  // Offset binary to two's complement: flip the sign bit
  function automatic sac_code_t sac_to_twos(input sac_code_t ob);
    sac_to_twos = {~ob[MSB_POS], ob[MSB_POS-1:LSB_POS]};
  endfunction

endpackage

/* File: rtl/sac_port.sv */
// Chip select / read-convert control port of a 12-bit sampling converter.
// Assumes host pins are synchronous to clk; the bus is resolved outside from result_oe.
`timescale 1ns/1ps

// Contract
// - Result outputs disabled when select high, read/convert low, or converting.
// - Result MSB sits on bit 11, LSB on bit 0.
// - Select low, read/convert falling: hold sample and start conversion.
// - Select low, idle, read/convert rising: enable result outputs.
// - Read/convert low, select falling: start conversion.
// - Read/convert high, idle, select falling: enable latest result.
// - Busy low from start until result stored in output register.
// - Select low, read/convert high: valid data when busy rises.
// - Conversion requests while busy is low are ignored.
// - Results are two's complement across twelve bits.
module sac_port
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host control
  input wire logic cs_n,
  input wire logic rd_conv,
  // Host status and data
  output logic busy_n,
  output sac_code_t result_bits,
  output logic result_oe,
  // Analog front end
  output sac_code_t dac_trial,
  input wire logic cmp_above
);

  typedef enum logic {PORT_IDLE, PORT_CONV} sac_port_e;

  sac_conv_if cv ();

  sac_port_e state_reg, state_next;
  logic req_reg, req_next;
  sac_code_t result_reg, result_next;
  logic conv_req;

  // Select and read/convert low together form the convert request
  assign conv_req = !cs_n && !rd_conv;

  assign cv.start = conv_req && !req_reg && (state_reg == PORT_IDLE);

  // Next-state for the port
  always_comb begin
    state_next = state_reg;
    result_next = result_reg;
    req_next = conv_req;
    case (state_reg)
      PORT_IDLE: begin
        if (cv.start) begin
          state_next = PORT_CONV;
        end
      end
      PORT_CONV: begin
        if (cv.done) begin
          result_next = cv.code;
          state_next = PORT_IDLE;
        end
      end
      default: state_next = PORT_IDLE;
    endcase
  end

  // Port registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= PORT_IDLE;
      req_reg <= 1'b0;
      result_reg <= RESULT_RST;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      result_reg <= result_next;
    end
  end

  assign busy_n = (state_reg == PORT_IDLE);
  assign result_bits = result_reg;
  // drive only when read-selected and idle
  assign result_oe = !cs_n && rd_conv && busy_n;

  sac_sar_core u_core (
    .clk(clk),
    .rstn(rstn),
    .cv(cv),
    .dac_trial(dac_trial),
    .cmp_above(cmp_above)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Busy-low span of one conversion, in cycles
  localparam int BUSY_SPAN = CONV_CYCLES + 1;

  logic [CNT_W:0] low_cnt_reg, low_cnt_next;

  // Busy-low length, cleared while busy is high
  always_comb begin
    low_cnt_next = low_cnt_reg + 6'h01;
    if (busy_n) begin
      low_cnt_next = '0;
    end
  end

  // Busy-low length register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_cnt_reg <= '0;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end

  // New convert request seen while idle
  sequence s_req_edge;
    busy_n && !cs_n && !rd_conv && !$past(!cs_n && !rd_conv);
  endsequence

  // Busy low for the first 8 cycles and again on the 24th, then high
  sequence s_full_conv;
    (!busy_n)[*8] ##16 !busy_n ##1 busy_n;
  endsequence

  // Busy returning high
  sequence s_busy_end;
    !busy_n ##1 busy_n;
  endsequence

  // Request level held over two edges
  sequence s_held_req;
    !cs_n && !rd_conv && $past(!cs_n && !rd_conv);
  endsequence

  chk_oe_off_cases: assert property (cs_n || !rd_conv || !busy_n |-> !result_oe)
    else $error("result outputs enabled when they must float");

  chk_cs_high_float: assert property (cs_n |-> !result_oe)
    else $error("result outputs enabled while deselected");

  chk_oe_off_busy: assert property (!busy_n |-> !result_oe)
    else $error("result outputs enabled during a conversion");

  chk_oe_on_read: assert property (!cs_n && rd_conv && busy_n |-> result_oe)
    else $error("result outputs not enabled for a read");

  chk_rd_rise_read: assert property ($rose(rd_conv) && !cs_n && busy_n |-> result_oe)
    else $error("read/convert rise did not enable result");

  chk_cs_fall_read: assert property ($fell(cs_n) && rd_conv && busy_n |-> result_oe)
    else $error("select fall did not enable latest result");

  chk_start_busy: assert property (s_req_edge |=> s_full_conv)
    else $error("request edge did not give a full busy period");

  chk_rc_fall_start: assert property ($fell(rd_conv) && !cs_n && busy_n |=> !busy_n)
    else $error("read/convert fall with select low did not start");

  chk_start_trial: assert property (cv.start |=> dac_trial == TRIAL_START)
    else $error("conversion did not start from the first trial code");

  chk_cs_start: assert property ($fell(cs_n) && !rd_conv && busy_n |=> !busy_n)
    else $error("select fall with read/convert low did not start");

  chk_busy_bound: assert property (low_cnt_reg <= 6'(BUSY_SPAN))
    else $error("busy low longer than one conversion");

  chk_no_start_busy: assert property (!busy_n |-> !cv.start)
    else $error("conversion start raised while busy");

  chk_held_no_restart: assert property (s_busy_end ##0 s_held_req |=> busy_n)
    else $error("held request restarted a conversion");

  chk_data_at_rise: assert property ($rose(busy_n) |-> result_bits == $past(cv.code))
    else $error("busy rose without the new result stored");

  chk_busy_length: assert property ($rose(busy_n) |-> low_cnt_reg == BUSY_SPAN)
    else $error("busy low for the wrong number of cycles");

  chk_result_stable: assert property (busy_n && $past(busy_n) |-> $stable(result_bits))
    else $error("result changed outside a busy rise");

  chk_done_to_idle: assert property (cv.done |=> busy_n && result_bits == $past(cv.code))
    else $error("conversion done without busy rising");

  chk_valid_on_rise: assert property ($rose(busy_n) && !cs_n && rd_conv |-> result_oe)
    else $error("data not on bus when busy rose");

  chk_twos_code: assert property ($rose(busy_n) |-> result_bits == {~dac_trial[11], dac_trial[10:0]})
    else $error("result not two's complement of final trial");

endmodule

/* File: rtl/sac_sar_core.sv */
// Successive approximation engine, one bit decided per cycle.
// Assumes an external comparator answers the trial code within one cycle.
`timescale 1ns/1ps
module sac_sar_core
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Controller side
  sac_conv_if.core cv,
  // Analog side
  output sac_code_t dac_trial,
  input wire logic cmp_above
);

  typedef enum logic {SAR_IDLE, SAR_RUN} sac_sar_e;

  sac_sar_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  sac_code_t trial_reg, trial_next;
  sac_code_t code_reg, code_next;
  logic done_reg, done_next;
  logic [3:0] pos;

  assign pos = 4'(MSB_POS) - cnt_reg[3:0];

  // Next-state: trial bits decided, then wait out the conversion time
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    trial_next = trial_reg;
    code_next = code_reg;
    done_next = 1'b0;
    case (state_reg)
      SAR_IDLE: begin
        if (cv.start) begin
          state_next = SAR_RUN;
          cnt_next = '0;
          trial_next = TRIAL_START;
        end
      end
      SAR_RUN: begin
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg < CNT_BITS) begin
          if (!cmp_above) begin
            trial_next[pos] = 1'b0; // Trial too high
          end
          if (pos != 4'h0) begin
            trial_next[pos - 4'h1] = 1'b1;
          end
        end
        if (cnt_reg == CNT_LAST) begin
          code_next = sac_to_twos(trial_reg);
          done_next = 1'b1;
          state_next = SAR_IDLE;
        end
      end
      default: state_next = SAR_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= SAR_IDLE;
      cnt_reg <= '0;
      trial_reg <= TRIAL_START;
      code_reg <= RESULT_RST;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      trial_reg <= trial_next;
      code_reg <= code_next;
      done_reg <= done_next;
    end
  end

  assign dac_trial = trial_reg;
  assign cv.code = code_reg;
  assign cv.done = done_reg; // One-cycle pulse

endmodule
